//--- rtl/ballast_mode_sequencer.sv
`include "ballast_params.svh"
`default_nettype none
module ballast_mode_sequencer #(
    parameter int SOFT_HALF = `SOFT_HALF_DEFAULT,
    parameter int WARM_HALF = `WARM_HALF_DEFAULT,
    parameter int RUN_HALF  = `RUN_HALF_DEFAULT,
    parameter int RAMP_DIV  = `RAMP_DIV_DEFAULT
) (
    input  wire logic                   clk_sys,
    input  wire logic                   arst_n,
    input  wire ballast_pkg::comparator_t comparators,
    output var  ballast_pkg::drive_t    drives,
    output var  ballast_pkg::mode_t     mode
);
    import ballast_pkg::*;

    localparam int CW = 16;
    localparam int FW = 7;

    // ------------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------------
    // Refused at elaboration so a bad half period never reaches the counters
    if (SOFT_HALF < 1 || SOFT_HALF > WARM_HALF || WARM_HALF > RUN_HALF ||
        RUN_HALF >= (1 << CW) || RAMP_DIV < 1 || RAMP_DIV >= (1 << CW)) begin
        $error("ballast_mode_sequencer: unsupported half period settings");
    end

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        comparator_t [`SYNC_STAGES-1:0] sync;
        comparator_t                    cmp;
        mode_t                          mode;
        phase_t                         phase;
        logic [CW-1:0]                  cnt;
        logic [CW-1:0]                  half;
        logic [CW-1:0]                  ramp;
        logic                           boot_ready;
        logic                           oc_seen;
        logic [FW-1:0]                  faults;
        logic                           discharging;
        drive_t                         out;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    localparam logic [CW-1:0] DEAD  = CW'(`DEAD_CYCLES);
    localparam logic [CW-1:0] SOFTH = CW'(SOFT_HALF);
    localparam logic [CW-1:0] WARMH = CW'(WARM_HALF);
    localparam logic [CW-1:0] RUNH  = CW'(RUN_HALF);
    localparam logic [CW-1:0] RDIV  = CW'(RAMP_DIV);
    localparam logic [FW-1:0] LIMIT = FW'(`FAULT_EVENT_LIMIT);

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        logic bottom_done;
        logic oscillating;
        bottom_done = 1'b0;
        oscillating = 1'b0;
        nxt_st = st_ff;
        nxt_st.out.frequency_raise = 1'b0;

        // Three-stage synchroniser; a change counts once stages two and three agree
        nxt_st.sync = {st_ff.sync[`SYNC_STAGES-2:0], comparators};
        if (st_ff.sync[1] == st_ff.sync[2]) begin
            nxt_st.cmp = st_ff.sync[2];
        end

        oscillating = (st_ff.mode == filament_warming_state) ||
                      (st_ff.mode == strike_state) || (st_ff.mode == run_state);

        // Bridge phase timing: equal on-times and equal dead times keep 50% duty
        if (oscillating) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
            case (st_ff.phase)
                ph_dead_low: begin
                    if (st_ff.cnt + 1'b1 >= DEAD) begin
                        nxt_st.phase = ph_low_on;
                        nxt_st.cnt = '0;
                        nxt_st.oc_seen = 1'b0;
                    end
                end
                ph_low_on: begin
                    // Sense only counts inside the bottom on-time
                    if (st_ff.cmp.current_over) begin
                        nxt_st.oc_seen = 1'b1;
                    end
                    if (st_ff.cmp.floating_supply_ok) begin
                        nxt_st.boot_ready = 1'b1;
                    end
                    if (st_ff.cnt + 1'b1 >= st_ff.half) begin
                        nxt_st.phase = ph_dead_high;
                        nxt_st.cnt = '0;
                        bottom_done = 1'b1;
                    end
                end
                ph_dead_high: begin
                    if (st_ff.cnt + 1'b1 >= DEAD) begin
                        nxt_st.phase = ph_high_on;
                        nxt_st.cnt = '0;
                    end
                end
                default: begin
                    // The top switch slot runs even before the floating supply is up
                    if (st_ff.cnt + 1'b1 >= st_ff.half) begin
                        nxt_st.phase = ph_dead_low;
                        nxt_st.cnt = '0;
                    end
                end
            endcase
        end

        // Fault counter, stepped once per bottom cycle
        if (bottom_done && st_ff.out.fault_counter_enable) begin
            // Last on-time cycle counts too; the latch would only see it next cycle
            if (st_ff.oc_seen || st_ff.cmp.current_over) begin
                nxt_st.faults = st_ff.faults + 1'b1;
            end else if (st_ff.faults != '0) begin
                nxt_st.faults = st_ff.faults - 1'b1;
            end
        end

        // Mode sequencing
        case (st_ff.mode)
            supply_lockout_state: begin
                nxt_st.phase = ph_dead_low;
                nxt_st.cnt = '0;
                nxt_st.boot_ready = 1'b0;
                nxt_st.faults = '0;
                nxt_st.discharging = 1'b0;
                nxt_st.half = SOFTH;
                if (st_ff.cmp.supply_above_start && st_ff.cmp.shutdown_below_reset) begin
                    nxt_st.mode = filament_warming_state;
                end
            end
            filament_warming_state: begin
                // Soft start: one cycle longer each bottom cycle until warm-up rate
                if (bottom_done && st_ff.half < WARMH) begin
                    nxt_st.half = st_ff.half + 1'b1;
                end
                if (st_ff.faults >= LIMIT) begin
                    nxt_st.mode = fault_state;
                end else if (st_ff.cmp.timer_above_two_thirds) begin
                    nxt_st.mode = strike_state;
                    nxt_st.discharging = 1'b1;
                    nxt_st.faults = '0;
                    nxt_st.ramp = '0;
                end
            end
            strike_state: begin
                // Shutdown and wear-out inputs are not looked at here
                if (st_ff.discharging && st_ff.cmp.timer_below_one_third) begin
                    nxt_st.discharging = 1'b0;
                end
                if (bottom_done && st_ff.cmp.current_over | st_ff.oc_seen &&
                    st_ff.half > SOFTH) begin
                    nxt_st.half = st_ff.half - 1'b1;
                    nxt_st.out.frequency_raise = 1'b1;
                end else if (st_ff.half < RUNH) begin
                    // Slow ramp toward the run rate; rate is set by RAMP_DIV
                    nxt_st.ramp = st_ff.ramp + 1'b1;
                    if (st_ff.ramp + 1'b1 >= RDIV) begin
                        nxt_st.ramp = '0;
                        nxt_st.half = st_ff.half + 1'b1;
                    end
                end
                if (!st_ff.discharging && st_ff.cmp.timer_above_two_thirds) begin
                    nxt_st.mode = run_state;
                    nxt_st.half = RUNH;
                end
            end
            run_state: begin
                if (st_ff.faults >= LIMIT || st_ff.cmp.wearout_fault) begin
                    nxt_st.mode = fault_state;
                end
            end
            default: begin
                // Latched off until power drops or shutdown is raised
                nxt_st.phase = ph_dead_low;
                nxt_st.cnt = '0;
                if (st_ff.cmp.shutdown_above_off) begin
                    nxt_st.mode = supply_lockout_state;
                end
            end
        endcase

        // Supply loss and shutdown return to lockout; strike ignores shutdown
        if (!st_ff.cmp.supply_above_start) begin
            nxt_st.mode = supply_lockout_state;
        end else if (st_ff.cmp.shutdown_above_off && st_ff.mode != strike_state) begin
            nxt_st.mode = supply_lockout_state;
        end

        // Registered outputs from the next mode and phase
        nxt_st.out.bottom_switch_drive = (nxt_st.mode == filament_warming_state ||
            nxt_st.mode == strike_state || nxt_st.mode == run_state) &&
            nxt_st.phase == ph_low_on;
        nxt_st.out.top_switch_drive = (nxt_st.mode == filament_warming_state ||
            nxt_st.mode == strike_state || nxt_st.mode == run_state) &&
            nxt_st.phase == ph_high_on && nxt_st.boot_ready;
        // A raise only stands while strike is kept; a same-cycle exit drops it
        nxt_st.out.frequency_raise = nxt_st.out.frequency_raise &&
            nxt_st.mode == strike_state;
        nxt_st.out.timer_ground_on = nxt_st.mode == supply_lockout_state ||
            nxt_st.mode == fault_state;
        nxt_st.out.timer_discharge_on = nxt_st.mode == strike_state &&
            nxt_st.discharging;
        nxt_st.out.frequency_clamp_switch = nxt_st.mode != strike_state &&
            nxt_st.mode != run_state;
        nxt_st.out.fault_counter_enable = nxt_st.mode == filament_warming_state ||
            nxt_st.mode == run_state;
        nxt_st.out.input_correction_high_gain = nxt_st.mode == filament_warming_state ||
            nxt_st.mode == strike_state;
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
            st_ff.mode <= supply_lockout_state;
            st_ff.half <= SOFTH;
            st_ff.out.timer_ground_on <= 1'b1;
            st_ff.out.frequency_clamp_switch <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign drives = st_ff.out;
    assign mode   = st_ff.mode;
endmodule
`default_nettype wire

//--- include/ballast_params.svh
`ifndef BALLAST_PARAMS_SVH
`define BALLAST_PARAMS_SVH
// ----------------------------------------------------------------------------
// Timing and limits
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS      50
`define DEAD_TIME_NS       1600
// Least time, rounded up to whole clock cycles
`define DEAD_CYCLES        ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAULT_EVENT_LIMIT  65
`define SYNC_STAGES        3
// Default half periods of the bridge in clock cycles (drive on-time per switch)
`define SOFT_HALF_DEFAULT  250
`define WARM_HALF_DEFAULT  500
`define RUN_HALF_DEFAULT   800
`define RAMP_DIV_DEFAULT   64
`endif

//--- include/ballast_pkg.sv
`default_nettype none
package ballast_pkg;
    // Operating modes of the sequencer
    typedef enum logic [2:0] {
        supply_lockout_state,
        filament_warming_state,
        strike_state,
        run_state,
        fault_state
    } mode_t;

    // Bridge switching phases
    typedef enum logic [1:0] {
        ph_dead_low,
        ph_low_on,
        ph_dead_high,
        ph_high_on
    } phase_t;

    // Digital results of the analog comparators
    typedef struct packed {
        logic supply_above_start;     // Supply above supply_start_threshold
        logic floating_supply_ok;     // Floating supply above its start threshold
        logic shutdown_below_reset;   // Shutdown input below 3.0 V
        logic shutdown_above_off;     // Shutdown input above non-latched off level
        logic wearout_fault;          // End-of-life window violated
        logic timer_above_two_thirds; // warmup_timer_node above 2/3 supply
        logic timer_below_one_third;  // warmup_timer_node below 1/3 supply
        logic current_over;           // Bridge current sense above 1.2 V
    } comparator_t;

    // Switches and drives facing the analog side
    typedef struct packed {
        logic top_switch_drive;
        logic bottom_switch_drive;
        logic timer_ground_on;        // Ties warmup_timer_node to ground
        logic timer_discharge_on;     // Rapid discharge toward 1/3 supply
        logic frequency_clamp_switch; // Grounds frequency_control_node
        logic frequency_raise;        // One clock-cycle pulse: nudge frequency up
        logic fault_counter_enable;
        logic input_correction_high_gain;
    } drive_t;
endpackage
`default_nettype wire

//--- test/ballast_seq_props.sv
`include "ballast_params.svh"
`default_nettype none
// ----------------------------------------
// Mode sequencer checks at the ports
// ----------------------------------------
module ballast_seq_props (
    input wire logic                     clk_sys,
    input wire logic                     arst_n,
    input wire ballast_pkg::comparator_t comparators,
    input wire ballast_pkg::drive_t      drives,
    input wire ballast_pkg::mode_t       mode
);
    timeunit 1ns;
    timeprecision 1ns;
    import ballast_pkg::*;
    typedef struct packed {
        logic [7:0] gap;
        logic       boot;
    } watch_t;
    watch_t    w_ff;
    watch_t    nxt_w;
    wire logic hi = drives.top_switch_drive;
    wire logic lo = drives.bottom_switch_drive;
    // Idle gap length and boot readiness; gap saturates so long lockouts stay legal
    always_comb begin
        nxt_w = w_ff;
        nxt_w.gap = (hi || lo) ? 8'h00 : w_ff.gap + {7'h00, w_ff.gap != 8'hff};
        if (comparators.floating_supply_ok && lo) nxt_w.boot = 1'h1;
        if (mode == supply_lockout_state) nxt_w.boot = 1'h0;
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) w_ff <= '0;
        else w_ff <= nxt_w;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    a_lockout_quiet: assert property (mode == supply_lockout_state
        |-> !hi && !lo && drives.timer_ground_on) else $error("drive in lockout");
    a_leave_lockout: assert property (mode == filament_warming_state
        && $past(mode) == supply_lockout_state |-> $past(comparators.supply_above_start, 4)
        && $past(comparators.shutdown_below_reset, 4)) else $error("early start");
    a_top_after_boot: assert property ($rose(hi) |-> w_ff.boot)
        else $error("top before boot");
    a_no_overlap: assert property (!(hi && lo)) else $error("overlap");
    a_dead_time: assert property ($rose(hi) || $rose(lo)
        |-> w_ff.gap >= `DEAD_CYCLES) else $error("short dead time");
    a_warm_outputs: assert property (mode == filament_warming_state
        |-> !drives.timer_ground_on && drives.frequency_clamp_switch
        && drives.input_correction_high_gain && drives.fault_counter_enable)
        else $error("warm-up outputs");
    a_strike_outputs: assert property (mode == strike_state
        |-> !drives.frequency_clamp_switch && !drives.fault_counter_enable
        && drives.input_correction_high_gain) else $error("strike outputs");
    a_discharge_strike: assert property (drives.timer_discharge_on
        |-> mode == strike_state) else $error("discharge outside strike");
    a_raise_pulse: assert property (drives.frequency_raise
        |-> mode == strike_state ##1 !drives.frequency_raise) else $error("raise pulse");
    a_strike_exit: assert property (mode == strike_state ##1 mode != strike_state
        |-> mode == run_state || mode == supply_lockout_state) else $error("strike exit");
    a_fault_quiet: assert property (mode == fault_state |-> !hi && !lo)
        else $error("drive in fault");
    c_strike: cover property (mode == strike_state);
    c_run: cover property (mode == run_state);
    c_fault: cover property (mode == fault_state);
endmodule
bind ballast_mode_sequencer ballast_seq_props u_ballast_seq_props (
    .clk_sys(clk_sys), .arst_n(arst_n), .comparators(comparators), .drives(drives), .mode(mode)
);
`default_nettype wire

//--- test/ballast_bridge_model.sv
`default_nettype none
// ----------------------------------------
// Bridge, boot supply and timer node
// ----------------------------------------
module ballast_bridge_model #(
    parameter int RATE = 100
) (
    input wire logic                clk_sys,
    input wire logic                arst_n,
    input wire ballast_pkg::drive_t drives,
    input wire logic                over_cmd,
    output logic                    float_ok,
    output logic                    t_hi,
    output logic                    t_lo,
    output logic                    cur
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] t_ff;
    logic [7:0] div_ff;
    logic [1:0] cnt_ff;
    logic       bot_q;
    // Timer node grounded, pulled down fast, or charged slowly by its resistor
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            t_ff <= 7'h00;
            div_ff <= 8'h00;
            cnt_ff <= 2'h0;
            bot_q <= 1'h0;
        end else begin
            bot_q <= drives.bottom_switch_drive;
            div_ff <= (div_ff == 8'(RATE - 1)) ? 8'h00 : div_ff + 8'h01;
            if (drives.timer_ground_on) t_ff <= 7'h00;
            else if (drives.timer_discharge_on) t_ff <= t_ff - {6'h00, t_ff != 7'h00};
            else if (div_ff == 8'h00 && t_ff != 7'h64) t_ff <= t_ff + 7'h01;
            // Boot capacitor charges only in bottom on-times, so it takes a few pulses
            if (drives.bottom_switch_drive && !bot_q && cnt_ff != 2'h3) cnt_ff <= cnt_ff + 2'h1;
        end
    end
    assign float_ok = (cnt_ff == 2'h3);
    assign t_hi = (t_ff >= 7'h43);
    assign t_lo = (t_ff <= 7'h21);
    assign cur = over_cmd && drives.bottom_switch_drive; // Sense sees low-side current only
endmodule
`default_nettype wire

//--- test/ballast_mode_sequencer_tb.sv
`include "ballast_params.svh"
`default_nettype none
// ----------------------------------------
// Sequencer bench
// ----------------------------------------
module ballast_mode_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ballast_pkg::*;
    localparam int WARM = 8;
    typedef struct packed {
        logic [4:0] in;
        logic [7:0] hold;
        mode_t      m;
        logic [5:0] d;
    } row_t;
    logic        clk_sys = 1'h0;
    logic        arst_n = 1'h0;
    logic        supply = 1'h0;
    logic        sd_lo = 1'h0;
    logic        sd_hi = 1'h0;
    logic        wear = 1'h0;
    logic        over = 1'h0;
    logic        f_ok, t_hi, t_lo, cur;
    drive_t      drives;
    mode_t       mode;
    comparator_t cmp;
    int          n_fail = 0;
    int          checked = 0;
    int          n;
    // Inputs {supply, shutdown low, shutdown high, wear-out, over-current}, hold, mode,
    // Expected low six drive bits {ground, discharge, clamp, raise, counter, high gain}
    row_t        rows [10] = '{
        '{5'h10, 8'h20, supply_lockout_state, 6'h28},
        '{5'h18, 8'h00, filament_warming_state, 6'h0b},
        '{5'h18, 8'h00, strike_state, 6'h11},
        '{5'h1e, 8'h64, strike_state, 6'h01},
        '{5'h18, 8'h00, run_state, 6'h02},
        '{5'h1a, 8'h00, fault_state, 6'h28},
        '{5'h14, 8'h00, supply_lockout_state, 6'h28},
        '{5'h19, 8'h00, filament_warming_state, 6'h0b},
        '{5'h19, 8'h00, fault_state, 6'h28},
        '{5'h08, 8'h00, supply_lockout_state, 6'h28}
    };
    assign cmp = {supply, f_ok, sd_lo, sd_hi, wear, t_hi, t_lo, cur};
    always #25 clk_sys = ~clk_sys;
    ballast_mode_sequencer #(.SOFT_HALF(4), .WARM_HALF(WARM), .RUN_HALF(12), .RAMP_DIV(2))
        u_ballast_mode_sequencer (.clk_sys(clk_sys), .arst_n(arst_n), .comparators(cmp),
        .drives(drives), .mode(mode));
    ballast_bridge_model #(.RATE(100)) u_ballast_bridge_model (.clk_sys(clk_sys),
        .arst_n(arst_n), .drives(drives), .over_cmd(over), .float_ok(f_ok), .t_hi(t_hi),
        .t_lo(t_lo), .cur(cur));
    task automatic stop_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Counts cycles while masked {mode, drives} match val (same) or not; bounded
    task automatic watch(input logic [10:0] mask, input logic [10:0] val, input logic same);
        n = 0;
        while (((({mode, drives} & mask) === val) == same) && n < 12000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n == 12000) begin
            n_fail++;
            stop_test();
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        #1;
        check("reset drives", 16'(drives), 16'h0028);
        repeat (14) @(posedge clk_sys);
        arst_n <= 1'h1;
        // Ordinary mode walk, one row at a time
        foreach (rows[i]) begin
            @(posedge clk_sys);
            {supply, sd_lo, sd_hi, wear, over} <= rows[i].in;
            repeat (rows[i].hold) @(posedge clk_sys);
            #1;
            watch(11'h700, {rows[i].m, 8'h00}, 1'h0);
            check("mode", 16'(mode), 16'(rows[i].m));
            check("side drives", 16'(drives[5:0]), 16'(rows[i].d));
        end
        // Warm-up waveform after the soft start has settled
        @(posedge clk_sys);
        {supply, sd_lo, over} <= 3'h6;
        repeat (6) begin
            watch(11'h0c0, 11'h000, 1'h0);
            watch(11'h0c0, 11'h040, 1'h0);
        end
        watch(11'h0c0, 11'h040, 1'h1);
        check("bottom on", 16'(n), 16'(WARM));
        watch(11'h0c0, 11'h000, 1'h1);
        check("dead after bottom", 16'(n), 16'(`DEAD_CYCLES));
        watch(11'h0c0, 11'h080, 1'h1);
        check("top on", 16'(n), 16'(WARM));
        watch(11'h0c0, 11'h000, 1'h1);
        check("dead after top", 16'(n), 16'(`DEAD_CYCLES));
        // Over-current during strike nudges frequency instead of faulting
        watch(11'h700, {strike_state, 8'h00}, 1'h0);
        @(posedge clk_sys);
        over <= 1'h1;
        #1;
        watch(11'h004, 11'h004, 1'h0);
        check("raise mode", 16'(mode), 16'(strike_state));
        // Reset in mid-strike must drop straight to the quiet lockout outputs
        @(posedge clk_sys);
        arst_n <= 1'h0;
        #1;
        check("reset drives", 16'(drives), 16'h0028);
        check("reset mode", 16'(mode), 16'(supply_lockout_state));
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'h1;
        // Synchroniser is refilled after reset, so the restart waits a few edges
        repeat (2) @(posedge clk_sys);
        #1;
        check("mode after reset", 16'(mode), 16'(supply_lockout_state));
        watch(11'h700, {filament_warming_state, 8'h00}, 1'h0);
        check("restart mode", 16'(mode), 16'(filament_warming_state));
        stop_test();
    end
endmodule
`default_nettype wire
